// File: hdl/irq_ctl_pkg.sv
// constants shared by the vectored interrupt controller and its priority picker
package irq_ctl_pkg;
  // source layout inside the 20-bit flag vector
  localparam int NUM_SRC = 20;
  localparam int SER_LSB = 0;
  localparam int SER_W = 8;
  localparam int DMA_LSB = 8;
  localparam int DMA_W = 8;
  localparam int TMR_LSB = 16;
  localparam int TMR_W = 4;
  localparam int GRP_W = 8;
  localparam int IDX_W = 3;
  // register addresses on the slave address pins
  localparam logic [6:0] ADDR_STATUS_0 = 7'h00;
  localparam logic [6:0] ADDR_STATUS_1 = 7'h01;
  localparam logic [6:0] ADDR_STATUS_2 = 7'h02;
  localparam logic [6:0] ADDR_MASK_0 = 7'h04;
  localparam logic [6:0] ADDR_MASK_1 = 7'h05;
  localparam logic [6:0] ADDR_MASK_2 = 7'h06;
  localparam logic [6:0] ADDR_CONTROL = 7'h08;
  localparam logic [6:0] ADDR_FIXED_VEC = 7'h0A;
  localparam logic [6:0] ADDR_MOD_VEC = 7'h0B;
  // control register fields
  localparam int CTL_ACK_LO = 0;
  localparam int CTL_ACK_HI = 1;
  localparam int CTL_VOS = 2;
  localparam int CTL_SWAP = 3;
  localparam int CTL_W = 4;
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_DOUBLE = 2'h2;
  // modified vector: user bits on top, source code below
  localparam int MODV_CODE_W = 6;
  localparam int MODV_USER_W = 2;
  localparam logic [5:0] CODE_NONE = 6'h00;
  localparam logic [5:0] CODE_SER_BASE = 6'h01;
  localparam logic [5:0] CODE_DMA_BASE = 6'h09;
  localparam logic [5:0] CODE_TMR_BASE = 6'h11;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [19:0] RST_FLAGS = 20'h0_0000;
endpackage

// File: hdl/source_prioritizer.sv
// picks the highest-priority active source and registers its six-bit code
`timescale 1ns/1ps
module source_prioritizer (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // unmasked active flags and group order
  input wire logic [irq_ctl_pkg::NUM_SRC-1:0] active_i,
  input wire logic swap_i,
  // winning code
  output logic [irq_ctl_pkg::MODV_CODE_W-1:0] code_o
);
  import irq_ctl_pkg::*;

  logic [MODV_CODE_W-1:0] code_r;
  logic [MODV_CODE_W-1:0] code_nxt;
  logic [GRP_W-1:0] ser_v;
  logic [GRP_W-1:0] dma_v;
  logic [GRP_W-1:0] tmr_v;

  // lowest set bit wins inside a group
  function automatic logic [IDX_W-1:0] first_set(input logic [GRP_W-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = GRP_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  always_comb begin
    ser_v = active_i[SER_LSB +: SER_W];
    dma_v = active_i[DMA_LSB +: DMA_W];
    tmr_v = {{(GRP_W - TMR_W){1'b0}}, active_i[TMR_LSB +: TMR_W]};
    code_nxt = CODE_NONE;
    if (swap_i && (|dma_v)) begin
      code_nxt = CODE_DMA_BASE + MODV_CODE_W'(first_set(dma_v));
    end else if (|ser_v) begin
      code_nxt = CODE_SER_BASE + MODV_CODE_W'(first_set(ser_v));
    end else if (|dma_v) begin
      code_nxt = CODE_DMA_BASE + MODV_CODE_W'(first_set(dma_v));
    end else if (|tmr_v) begin
      code_nxt = CODE_TMR_BASE + MODV_CODE_W'(first_set(tmr_v));
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_r <= CODE_NONE;
    end else begin
      code_r <= code_nxt;
    end
  end

  assign code_o = code_r;

  property serial_first_p;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (!swap_i && (|active_i[SER_LSB +: SER_W]))
      |=> (code_r >= CODE_SER_BASE) && (code_r < CODE_DMA_BASE);
  endproperty
  serial_wins_a: assert property (serial_first_p)
    else $error("serial source did not win with normal order");

  property dma_first_p;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (swap_i && (|active_i[DMA_LSB +: DMA_W]))
      |=> (code_r >= CODE_DMA_BASE) && (code_r < CODE_TMR_BASE);
  endproperty
  dma_swap_wins_a: assert property (dma_first_p)
    else $error("dma source did not win with swapped order");
endmodule // source_prioritizer

// File: hdl/vectored_interrupt_control.sv
// vectored interrupt controller: flags, masks, request pin and acknowledge vector
//
// Behaviour
// - twenty sticky source flags in three status registers
// - three mask registers gate each flag
// - request pin low while unmasked flag active
// - acknowledge pin starts a vector cycle
// - two control bits pick acknowledge type
// - no-acknowledge type never drives vector
// - single type drives vector on first acknowledge
// - double type drives only on second acknowledge
// - select bit picks fixed or modified vector
// - fixed vector is output exactly as written
// - modified vector: two user bits, six code
// - code names highest-priority active source
// - swap bit exchanges serial and dma priority
// - flags come from serial, dma, timer units
`timescale 1ns/1ps
module vectored_interrupt_control (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register slave pins
  input wire logic reg_cs_n_i,
  input wire logic reg_rd_n_i,
  input wire logic reg_wr_n_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // event pulses from the source units
  input wire logic [irq_ctl_pkg::SER_W-1:0] serial_channel_unit_irq_i,
  input wire logic [irq_ctl_pkg::DMA_W-1:0] dma_unit_irq_i,
  input wire logic [irq_ctl_pkg::TMR_W-1:0] timer_irq_i,
  // host interrupt handshake
  output logic irq_n_o,
  input wire logic irq_ack_n_i
);
  import irq_ctl_pkg::*;

  localparam int SYNC_W = 19;

  // two-stage synchroniser for every pin input
  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic ack_n_s;
  logic [6:0] addr_s;
  logic [7:0] wdata_s;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta_r <= '1;
      pin_sync_r <= '1;
    end else begin
      pin_meta_r <= {reg_cs_n_i, reg_rd_n_i, reg_wr_n_i, irq_ack_n_i, reg_addr_i, data_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign {cs_n_s, rd_n_s, wr_n_s, ack_n_s, addr_s, wdata_s} = pin_sync_r;

  // register write capture: commit on the trailing edge of the strobe
  logic wr_act;
  logic rd_act;
  logic wr_act_r;
  logic wr_act_nxt;
  logic [6:0] waddr_r;
  logic [6:0] waddr_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic wr_commit;

  always_comb begin
    wr_act = !cs_n_s && !wr_n_s;
    rd_act = !cs_n_s && !rd_n_s;
    wr_act_nxt = wr_act;
    waddr_nxt = wr_act ? addr_s : waddr_r;
    wdata_nxt = wr_act ? wdata_s : wdata_r;
    wr_commit = wr_act_r && !wr_act;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_act_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= RST_BYTE;
    end else begin
      wr_act_r <= wr_act_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // flags, masks and control registers
  logic [NUM_SRC-1:0] src_ev;
  logic [NUM_SRC-1:0] status_r;
  logic [NUM_SRC-1:0] status_nxt;
  logic [NUM_SRC-1:0] status_clr;
  logic [NUM_SRC-1:0] mask_r;
  logic [NUM_SRC-1:0] mask_nxt;
  logic [CTL_W-1:0] ctl_r;
  logic [CTL_W-1:0] ctl_nxt;
  logic [7:0] fixed_vec_r;
  logic [7:0] fixed_vec_nxt;
  logic [MODV_USER_W-1:0] modv_user_r;
  logic [MODV_USER_W-1:0] modv_user_nxt;
  logic [NUM_SRC-1:0] pending;
  logic [MODV_CODE_W-1:0] src_code;
  logic [1:0] ack_mode;

  always_comb begin
    src_ev = {timer_irq_i, dma_unit_irq_i, serial_channel_unit_irq_i};
    status_clr = '0;
    mask_nxt = mask_r;
    ctl_nxt = ctl_r;
    fixed_vec_nxt = fixed_vec_r;
    modv_user_nxt = modv_user_r;
    if (wr_commit) begin
      unique case (waddr_r)
        // software clears a flag by writing one to it
        ADDR_STATUS_0: status_clr[SER_LSB +: SER_W] = wdata_r[SER_W-1:0];
        ADDR_STATUS_1: status_clr[DMA_LSB +: DMA_W] = wdata_r[DMA_W-1:0];
        ADDR_STATUS_2: status_clr[TMR_LSB +: TMR_W] = wdata_r[TMR_W-1:0];
        ADDR_MASK_0: mask_nxt[SER_LSB +: SER_W] = wdata_r[SER_W-1:0];
        ADDR_MASK_1: mask_nxt[DMA_LSB +: DMA_W] = wdata_r[DMA_W-1:0];
        ADDR_MASK_2: mask_nxt[TMR_LSB +: TMR_W] = wdata_r[TMR_W-1:0];
        ADDR_CONTROL: ctl_nxt = wdata_r[CTL_W-1:0];
        ADDR_FIXED_VEC: fixed_vec_nxt = wdata_r;
        ADDR_MOD_VEC: modv_user_nxt = wdata_r[7 -: MODV_USER_W];
        default: ;
      endcase
    end
    // a new event beats a clear landing in the same cycle
    status_nxt = (status_r & ~status_clr) | src_ev;
    pending = status_r & mask_r;
    ack_mode = {ctl_r[CTL_ACK_HI], ctl_r[CTL_ACK_LO]};
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_r <= RST_FLAGS;
      mask_r <= RST_FLAGS;
      ctl_r <= '0;
      fixed_vec_r <= RST_BYTE;
      modv_user_r <= '0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      ctl_r <= ctl_nxt;
      fixed_vec_r <= fixed_vec_nxt;
      modv_user_r <= modv_user_nxt;
    end
  end

  source_prioritizer u_prio (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .active_i(pending),
    .swap_i(ctl_r[CTL_SWAP]),
    .code_o(src_code)
  );

  // request pin and acknowledge sequencing
  logic irq_n_r;
  logic irq_n_nxt;
  logic ack_act;
  logic ack_prev_r;
  logic ack_start;
  logic second_r;
  logic second_nxt;
  logic vec_drive_r;
  logic vec_drive_nxt;
  logic drive_now;
  logic [7:0] vector_r;
  logic [7:0] vector_nxt;
  logic [7:0] modv_rd;

  always_comb begin
    irq_n_nxt = !(|pending);
    ack_act = !ack_n_s;
    ack_start = ack_act && !ack_prev_r;
    modv_rd = {modv_user_r, src_code};
    drive_now = (ack_mode == ACK_SINGLE)
             || ((ack_mode == ACK_DOUBLE) && second_r);
    second_nxt = second_r;
    vector_nxt = vector_r;
    if (ack_mode != ACK_DOUBLE) begin
      second_nxt = 1'b0;
    end else if (ack_start) begin
      second_nxt = !second_r;
    end
    // the vector is frozen at the start so it cannot change mid-cycle
    if (ack_start) begin
      vector_nxt = ctl_r[CTL_VOS] ? modv_rd : fixed_vec_r;
    end
    // reserved code and no-acknowledge never drive
    vec_drive_nxt = ack_act && (ack_start ? drive_now : vec_drive_r);
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_n_r <= 1'b1;
      ack_prev_r <= 1'b0;
      second_r <= 1'b0;
      vec_drive_r <= 1'b0;
      vector_r <= RST_BYTE;
    end else begin
      irq_n_r <= irq_n_nxt;
      ack_prev_r <= ack_act;
      second_r <= second_nxt;
      vec_drive_r <= vec_drive_nxt;
      vector_r <= vector_nxt;
    end
  end

  // data pins: vector during acknowledge, register contents during read
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic dout_oe_r;
  logic dout_oe_nxt;
  logic [7:0] rd_mux;

  always_comb begin
    unique case (addr_s)
      ADDR_STATUS_0: rd_mux = status_r[SER_LSB +: SER_W];
      ADDR_STATUS_1: rd_mux = status_r[DMA_LSB +: DMA_W];
      ADDR_STATUS_2: rd_mux = {{(8 - TMR_W){1'b0}}, status_r[TMR_LSB +: TMR_W]};
      ADDR_MASK_0: rd_mux = mask_r[SER_LSB +: SER_W];
      ADDR_MASK_1: rd_mux = mask_r[DMA_LSB +: DMA_W];
      ADDR_MASK_2: rd_mux = {{(8 - TMR_W){1'b0}}, mask_r[TMR_LSB +: TMR_W]};
      ADDR_CONTROL: rd_mux = {{(8 - CTL_W){1'b0}}, ctl_r};
      ADDR_FIXED_VEC: rd_mux = fixed_vec_r;
      ADDR_MOD_VEC: rd_mux = modv_rd;
      default: rd_mux = RST_BYTE;
    endcase
    dout_oe_nxt = vec_drive_nxt || rd_act;
    dout_nxt = vec_drive_nxt ? vector_nxt : rd_mux;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dout_r <= RST_BYTE;
      dout_oe_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      dout_oe_r <= dout_oe_nxt;
    end
  end

  assign data_o = dout_r;
  assign data_oe_o = dout_oe_r;
  assign irq_n_o = irq_n_r;

  // checks
  sequence ack_begin_s;
    ack_act && !ack_prev_r;
  endsequence

  sequence double_first_s;
    ack_begin_s and ((ack_mode == ACK_DOUBLE) && !second_r);
  endsequence

  property flag_sticks_p;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (|src_ev) |=> ((status_r & $past(src_ev)) == $past(src_ev));
  endproperty
  flag_set_wins_a: assert property (flag_sticks_p)
    else $error("source event lost in status flags");

  masked_quiet_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ((mask_r == '0) [*2]) |-> irq_n_o)
    else $error("request raised with every source masked");

  request_raise_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (|pending) |=> !irq_n_o)
    else $error("request not raised for pending source");

  request_drop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !(|pending) |=> irq_n_o)
    else $error("request held with nothing pending");

  no_ack_silent_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ((ack_mode == ACK_NONE) throughout (ack_begin_s ##1 ack_act)) |-> !vec_drive_r)
    else $error("vector driven in no-acknowledge mode");

  single_drives_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ack_begin_s and (ack_mode == ACK_SINGLE) |=> vec_drive_r ##1 (data_oe_o || !ack_act))
    else $error("single acknowledge did not drive vector");

  double_first_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    double_first_s |=> !vec_drive_r && second_r)
    else $error("vector driven on first of double acknowledge");

  fixed_vector_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ack_begin_s and !ctl_r[CTL_VOS] |=> vector_r == $past(fixed_vec_r))
    else $error("fixed vector not selected");

  modified_code_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ack_begin_s and ctl_r[CTL_VOS]
    |=> vector_r == {$past(modv_user_r), $past(src_code)})
    else $error("modified vector content wrong");

  ack_start_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    vec_drive_r && !$past(vec_drive_r) |-> $past(ack_start))
    else $error("vector drive began without acknowledge");
endmodule // vectored_interrupt_control

// File: verification/host_model.sv
// host processor model: watches the request pin and drives acknowledge
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic mclk_i,
  // device pins seen by the host
  input wire logic irq_n_i,
  input wire logic data_oe_i,
  input wire logic [7:0] data_i,
  // acknowledge toward the device
  output logic irq_ack_n_o
);
  initial irq_ack_n_o = 1'b1;

  // one acknowledge assertion; hold stretches it to act as a slow host
  task automatic ack(input int hold, output logic oe, output logic [7:0] vec);
    // a real host only answers a pending request, so wait for it (bounded)
    for (int i = 0; i < 8 && irq_n_i !== 1'b0; i++) begin
      @(negedge mclk_i);
    end
    @(negedge mclk_i);
    irq_ack_n_o = 1'b0;
    repeat (4 + hold) @(negedge mclk_i);
    oe = data_oe_i;
    vec = data_i;
    irq_ack_n_o = 1'b1;
    // keep the pin high long enough for the device to see the release
    repeat (4) @(negedge mclk_i);
  endtask
endmodule // host_model

// File: verification/vectored_interrupt_control_tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module vectored_interrupt_control_tb;
  import irq_ctl_pkg::*;
  logic mclk_i;
  logic sys_rst_i;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic [7:0] data_bus;
  logic [7:0] data_o;
  logic data_oe;
  logic [7:0] ser;
  logic [7:0] dma;
  logic [3:0] tmr;
  logic irq_n;
  logic ack_n;
  int failures = 0;
  int comparisons = 0;

  // shared data pins: the device wins while it drives them
  assign data_bus = data_oe ? data_o : wr_data;

  vectored_interrupt_control dut (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .reg_cs_n_i(cs_n),
    .reg_rd_n_i(rd_n),
    .reg_wr_n_i(wr_n),
    .reg_addr_i(addr),
    .data_i(data_bus),
    .data_o(data_o),
    .data_oe_o(data_oe),
    .serial_channel_unit_irq_i(ser),
    .dma_unit_irq_i(dma),
    .timer_irq_i(tmr),
    .irq_n_o(irq_n),
    .irq_ack_n_i(ack_n)
  );

  host_model host (
    .mclk_i(mclk_i),
    .irq_n_i(irq_n),
    .data_oe_i(data_oe),
    .data_i(data_bus),
    .irq_ack_n_o(ack_n)
  );

  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    wr_data = d;
    repeat (3) @(negedge mclk_i);
    cs_n = 1'b1;
    wr_n = 1'b1;
    // idle data pins must not keep showing the old value
    wr_data = ~d;
    repeat (4) @(negedge mclk_i);
  endtask

  task automatic check_rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge mclk_i);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    repeat (4) @(negedge mclk_i);
    `CHK(data_oe, 1'b1)
    `CHK(data_o, exp)
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(negedge mclk_i);
  endtask

  task automatic pulse(input logic [7:0] s, input logic [7:0] d, input logic [3:0] t);
    @(negedge mclk_i);
    ser = s;
    dma = d;
    tmr = t;
    @(negedge mclk_i);
    ser = 8'h00;
    dma = 8'h00;
    tmr = 4'h0;
    repeat (3) @(negedge mclk_i);
  endtask

  task automatic ack_chk(input int hold, input logic exp_oe, input logic [7:0] exp_vec);
    logic oe;
    logic [7:0] vec;
    host.ack(hold, oe, vec);
    `CHK(oe, exp_oe)
    if (exp_oe) begin
      `CHK(vec, exp_vec)
    end
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // whole sequence needs well under 3000 cycles
  initial begin
    #50000;
    failures++;
    summarize();
  end

  initial begin
    sys_rst_i = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 7'h00;
    wr_data = 8'h00;
    ser = 8'h00;
    dma = 8'h00;
    tmr = 4'h0;
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    `CHK(irq_n, 1'b1)
    check_rd(ADDR_CONTROL, 8'h00);
    check_rd(ADDR_MASK_0, 8'h00);
    check_rd(7'h03, 8'h00);
    // a masked source latches but must stay silent
    pulse(8'h04, 8'h00, 4'h0);
    check_rd(ADDR_STATUS_0, 8'h04);
    `CHK(irq_n, 1'b1)
    reg_wr(ADDR_STATUS_0, 8'hFF);
    check_rd(ADDR_STATUS_0, 8'h00);
    reg_wr(ADDR_MASK_0, 8'hFF);
    reg_wr(ADDR_MASK_1, 8'hFF);
    reg_wr(ADDR_MASK_2, 8'h0F);
    check_rd(ADDR_MASK_2, 8'h0F);
    // three groups fire together
    pulse(8'h20, 8'h08, 4'h2);
    `CHK(irq_n, 1'b0)
    check_rd(ADDR_STATUS_1, 8'h08);
    check_rd(ADDR_STATUS_2, 8'h02);
    check_rd(ADDR_MOD_VEC, 8'h06);
    reg_wr(ADDR_MOD_VEC, 8'hFF);
    check_rd(ADDR_MOD_VEC, 8'hC6);
    reg_wr(ADDR_CONTROL, 8'h08);
    check_rd(ADDR_MOD_VEC, 8'hCC);
    reg_wr(ADDR_FIXED_VEC, 8'hA5);
    check_rd(ADDR_FIXED_VEC, 8'hA5);
    // every acknowledge encoding, fixed vector; double needs a second pass
    for (int m = 0; m < 4; m++) begin
      reg_wr(ADDR_CONTROL, m[7:0]);
      ack_chk(0, (m == 1), 8'hA5);
      if (m == 2) begin
        ack_chk(2, 1'b1, 8'hA5);
      end
    end
    reg_wr(ADDR_CONTROL, 8'h05);
    ack_chk(1, 1'b1, 8'hC6);
    reg_wr(ADDR_CONTROL, 8'h0D);
    ack_chk(0, 1'b1, 8'hCC);
    // drain sources one by one and follow the winner
    reg_wr(ADDR_STATUS_0, 8'h20);
    reg_wr(ADDR_CONTROL, 8'h00);
    check_rd(ADDR_MOD_VEC, 8'hCC);
    reg_wr(ADDR_STATUS_1, 8'h08);
    check_rd(ADDR_MOD_VEC, 8'hD2);
    `CHK(irq_n, 1'b0)
    reg_wr(ADDR_MASK_2, 8'h00);
    `CHK(irq_n, 1'b1)
    reg_wr(ADDR_MASK_2, 8'h0F);
    `CHK(irq_n, 1'b0)
    reg_wr(ADDR_STATUS_2, 8'h0F);
    `CHK(irq_n, 1'b1)
    check_rd(ADDR_STATUS_2, 8'h00);
    summarize();
  end
endmodule // vectored_interrupt_control_tb
